// *** hdl/alu_move_defs.svh ***
`ifndef ALU_MOVE_DEFS_SVH
`define ALU_MOVE_DEFS_SVH
`define FLAG_C 5'h00
`define FLAG_Z 5'h01
`define FLAG_N 5'h02
`define FLAG_V 5'h03
`define HIGH_REV 4'h2
`define SSRF_LONG_CYC 2'h3
`define TRUE_WORD 32'h0000_0001
`define FALSE_WORD 32'h0000_0000
`define SR_RESET 32'h0000_0000
`endif

// *** hdl/alu_move_pkg.sv ***
package alu_move_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_ROL, OP_ROR, OP_MOV_IMM, OP_MOV_REG, OP_MOVC_REG, OP_MOVC_IMM,
        OP_MOVH, OP_CSRF, OP_CSRFCZ, OP_SSRF, OP_SRC
    } alu_op_t;
    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [3:0] condition_code_field;
        logic [4:0] flag_bit_index;
        logic [31:0] dest_val;
        logic [31:0] source_reg;
        logic [31:0] imm;
        logic [3:0] rd;
        logic long_case;
    } issue_t;
    typedef struct packed {
        logic wr_en;
        logic [3:0] rd;
        logic [31:0] data;
    } wb_t;
    typedef enum logic [1:0] {ST_IDLE, ST_STALL} fsm_t;
    typedef struct packed {
        fsm_t st;
        logic [1:0] cnt;
        logic [31:0] sr;
        wb_t wb;
        logic busy;
        logic illegal;
        logic [3:0] rev;
    } state_t;
endpackage : alu_move_pkg

// *** hdl/cond_eval.sv ***
`timescale 1ns/1ps
`include "alu_move_defs.svh"
module cond_eval (
    input wire logic ref_clk,
    input wire logic [3:0] code,
    input wire logic [31:0] flags,
    output logic hold
);
    logic c, z, n, v;
    // combinational; ref_clk kept for a uniform leaf port list
    logic unused;
    assign unused = ref_clk;
    assign c = flags[`FLAG_C];
    assign z = flags[`FLAG_Z];
    assign n = flags[`FLAG_N];
    assign v = flags[`FLAG_V];
    always_comb begin
        case (code)
            4'h0: hold = z;
            4'h1: hold = !z;
            4'h2: hold = c;
            4'h3: hold = !c;
            4'h4: hold = n;
            4'h5: hold = !n;
            4'h6: hold = !(n ^ v);
            4'h7: hold = n ^ v;
            4'h8: hold = v;
            4'h9: hold = !v;
            4'ha: hold = !((n ^ v) | z);
            4'hb: hold = (n ^ v) | z;
            4'hc: hold = !c & !z;
            4'hd: hold = c | z;
            4'he: hold = 1'b1;
            default: hold = 1'b0;
        endcase
    end
endmodule : cond_eval

// *** hdl/alu_move_rotate_flag_ops.sv ***
`timescale 1ns/1ps
`include "alu_move_defs.svh"
module alu_move_rotate_flag_ops (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [3:0] core_rev,
    input alu_move_pkg::issue_t issue,
    output alu_move_pkg::wb_t wb,
    output logic [31:0] status_reg,
    output logic busy,
    output logic illegal
);
    import alu_move_pkg::*;
    // ************************************************
    // state
    // ************************************************
    state_t s_reg, s_next;
    logic cond_hold;
    logic [31:0] sr_in;
    logic [31:0] bitmask;

    cond_eval u_cond (
        .ref_clk(ref_clk),
        .code(issue.condition_code_field),
        .flags(s_reg.sr),
        .hold(cond_hold)
    );
    assign bitmask = 32'h0000_0001 << issue.flag_bit_index;
    assign sr_in = s_reg.sr;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        s_next = s_reg;
        s_next.wb.wr_en = 1'b0;
        s_next.illegal = 1'b0;
        s_next.rev = core_rev;
        s_next.wb.rd = issue.rd;
        case (s_reg.st)
            ST_IDLE: begin
                if (issue.valid) begin
                    case (issue.op)
                        OP_ROL: begin
                            s_next.wb.wr_en = 1'b1;
                            s_next.wb.data = {issue.dest_val[30:0], sr_in[`FLAG_C]};
                            s_next.sr[`FLAG_C] = issue.dest_val[31];
                        end
                        OP_ROR: begin
                            s_next.wb.wr_en = 1'b1;
                            s_next.wb.data = {sr_in[`FLAG_C], issue.dest_val[31:1]};
                            s_next.sr[`FLAG_C] = issue.dest_val[0];
                        end
                        OP_MOV_IMM: begin
                            s_next.wb.wr_en = 1'b1;
                            s_next.wb.data = issue.imm;
                        end
                        OP_MOV_REG: begin
                            s_next.wb.wr_en = 1'b1;
                            s_next.wb.data = issue.source_reg;
                        end
                        OP_MOVC_REG: begin
                            s_next.wb.wr_en = cond_hold;
                            s_next.wb.data = issue.source_reg;
                        end
                        OP_MOVC_IMM: begin
                            s_next.wb.wr_en = cond_hold;
                            s_next.wb.data = issue.imm;
                        end
                        OP_MOVH: begin
                            // older revisions flag the opcode rather than corrupt rd
                            if (core_rev >= `HIGH_REV) begin
                                s_next.wb.wr_en = 1'b1;
                                s_next.wb.data = {issue.imm[15:0], issue.dest_val[15:0]};
                            end else begin
                                s_next.illegal = 1'b1;
                            end
                        end
                        OP_CSRF: begin
                            s_next.sr = sr_in & ~bitmask;
                        end
                        OP_CSRFCZ: begin
                            s_next.sr[`FLAG_C] = sr_in[issue.flag_bit_index];
                            s_next.sr[`FLAG_Z] = sr_in[issue.flag_bit_index];
                        end
                        OP_SSRF: begin
                            s_next.sr = sr_in | bitmask;
                            if (issue.long_case) begin
                                s_next.st = ST_STALL;
                                s_next.cnt = `SSRF_LONG_CYC - 2'h1;
                                s_next.busy = 1'b1;
                            end
                        end
                        OP_SRC: begin
                            s_next.wb.wr_en = 1'b1;
                            s_next.wb.data = cond_hold ? `TRUE_WORD : `FALSE_WORD;
                        end
                        default: begin
                            s_next.wb.wr_en = 1'b0;
                        end
                    endcase
                end
            end
            ST_STALL: begin
                // issue is ignored while busy; decoder must hold it
                s_next.cnt = s_reg.cnt - 2'h1;
                if (s_reg.cnt == 2'h1) begin
                    s_next.st = ST_IDLE;
                    s_next.busy = 1'b0;
                end
            end
            default: begin
                s_next.st = ST_IDLE;
                s_next.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '{st: ST_IDLE, cnt: 2'h0, sr: `SR_RESET,
                wb: '{wr_en: 1'b0, rd: 4'h0, data: 32'h0000_0000},
                busy: 1'b0, illegal: 1'b0, rev: 4'h0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb = s_reg.wb;
    assign status_reg = s_reg.sr;
    assign busy = s_reg.busy;
    assign illegal = s_reg.illegal;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_rol_result: assert property (issue.valid && !busy && issue.op == OP_ROL |=> wb.wr_en && wb.data == {$past(issue.dest_val[30:0]), $past(status_reg[0])} && status_reg[0] == $past(issue.dest_val[31])) else $error("rol wrong");
    a_ror_result: assert property (issue.valid && !busy && issue.op == OP_ROR |=> wb.wr_en && wb.data == {$past(status_reg[0]), $past(issue.dest_val[31:1])} && status_reg[0] == $past(issue.dest_val[0])) else $error("ror wrong");
    a_mov_imm: assert property (issue.valid && !busy && issue.op == OP_MOV_IMM |=> wb.wr_en && wb.data == $past(issue.imm)) else $error("mov imm wrong");
    a_movc_reg: assert property (issue.valid && !busy && issue.op == OP_MOVC_REG |=> wb.wr_en == $past(cond_hold) && wb.data == $past(issue.source_reg)) else $error("cond move wrong");
    a_movc_imm: assert property (issue.valid && !busy && issue.op == OP_MOVC_IMM && !cond_hold |=> !wb.wr_en) else $error("cond imm wrote");
    a_movh_rev: assert property (issue.valid && !busy && issue.op == OP_MOVH |=> wb.wr_en == ($past(core_rev) >= 4'h2) && illegal != wb.wr_en) else $error("movh rev wrong");
    a_csrf_clear: assert property (issue.valid && !busy && issue.op == OP_CSRF |=> status_reg[$past(issue.flag_bit_index)] == 1'b0 && !wb.wr_en) else $error("csrf wrong");
    a_csrfcz_copy: assert property (issue.valid && !busy && issue.op == OP_CSRFCZ |=> status_reg[0] == status_reg[1] && status_reg[0] == $past(status_reg[issue.flag_bit_index])) else $error("csrfcz wrong");
    a_ssrf_long: assert property (issue.valid && !busy && issue.op == OP_SSRF && issue.long_case |=> busy [*2] ##1 !busy) else $error("ssrf stall wrong");
    a_ssrf_set: assert property (issue.valid && !busy && issue.op == OP_SSRF |=> status_reg[$past(issue.flag_bit_index)] && !wb.wr_en) else $error("ssrf bit not set");
    a_movc_imm_wr: assert property (issue.valid && !busy && issue.op == OP_MOVC_IMM && cond_hold |=> wb.wr_en && wb.data == $past(issue.imm)) else $error("cond imm not written");
    a_src_value: assert property (issue.valid && !busy && issue.op == OP_SRC |=> wb.wr_en && wb.data == ($past(cond_hold) ? 32'h0000_0001 : 32'h0000_0000)) else $error("sr cond wrong");
    a_mov_flags: assert property (issue.valid && !busy && issue.op == OP_MOV_REG |=> wb.data == $past(issue.source_reg) && $stable(status_reg)) else $error("mov reg wrong");

    c_rol: cover property (issue.valid && issue.op == OP_ROL);
    c_ssrf_long: cover property (issue.valid && !busy && issue.op == OP_SSRF && issue.long_case);
    c_movc_skip: cover property (issue.valid && issue.op == OP_MOVC_REG && !cond_hold);
    c_movh_old: cover property (issue.valid && issue.op == OP_MOVH && core_rev < 4'h2);
endmodule : alu_move_rotate_flag_ops

// *** tb/reg_file_model.sv ***
`timescale 1ns/1ps
module reg_file_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input alu_move_pkg::wb_t wb,
    input wire logic [3:0] rd_sel,
    output logic [31:0] rd_data
);
    import alu_move_pkg::*;
    // ****************************************
    // register file taking the writeback port
    // ****************************************
    logic [31:0] regs [16];
    // only pulses with wr_en write, so a skipped conditional op leaves no trace
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 32'h0000_0000;
            end
        end else if (wb.wr_en) begin
            regs[wb.rd] <= wb.data;
        end
    end
    assign rd_data = regs[rd_sel];
endmodule : reg_file_model

// *** tb/alu_move_rotate_flag_ops_tb.sv ***
`timescale 1ns/1ps
module alu_move_rotate_flag_ops_tb;
    import alu_move_pkg::*;
    typedef struct packed {
        alu_op_t op; logic [3:0] cc; logic [4:0] idx; logic [31:0] dv; logic [31:0] src;
        logic [31:0] imm; logic ewr; logic [31:0] ed; logic [31:0] esr;
    } row_t;
    localparam logic [31:0] Z0 = 32'h0000_0000;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] core_rev = 4'h2;
    issue_t issue = '0;
    wb_t wb;
    logic [31:0] status_reg;
    logic busy;
    logic illegal;
    logic [3:0] rd_sel = 4'h0;
    logic [31:0] rd_data;
    int failures = 0;
    int comparisons = 0;
    row_t rows [15] = '{
        '{OP_MOV_IMM, 4'h0, 5'h00, Z0, Z0, 32'h1234_5678, 1, 32'h1234_5678, Z0},
        '{OP_MOV_REG, 4'h0, 5'h00, Z0, 32'hdead_beef, Z0, 1, 32'hdead_beef, Z0},
        '{OP_MOVC_REG, 4'h0, 5'h00, Z0, 32'h5555_aaaa, Z0, 0, Z0, Z0},
        '{OP_MOVC_REG, 4'h1, 5'h00, Z0, 32'h5555_aaaa, Z0, 1, 32'h5555_aaaa, Z0},
        '{OP_MOVC_IMM, 4'hf, 5'h00, Z0, Z0, 32'h0000_00ff, 0, Z0, Z0},
        '{OP_MOVC_IMM, 4'he, 5'h00, Z0, Z0, 32'h0000_00ff, 1, 32'h0000_00ff, Z0},
        '{OP_SRC, 4'h0, 5'h00, Z0, Z0, Z0, 1, Z0, Z0},
        '{OP_SRC, 4'h1, 5'h00, Z0, Z0, Z0, 1, 32'h0000_0001, Z0},
        '{OP_ROL, 4'h0, 5'h00, 32'h8000_0001, Z0, Z0, 1, 32'h0000_0002, 32'h0000_0001},
        '{OP_ROR, 4'h0, 5'h00, 32'h0000_0002, Z0, Z0, 1, 32'h8000_0001, Z0},
        '{OP_MOVH, 4'h0, 5'h00, 32'h1111_2222, Z0, 32'h0000_abcd, 1, 32'habcd_2222, Z0},
        '{OP_SSRF, 4'h0, 5'h05, Z0, Z0, Z0, 0, Z0, 32'h0000_0020},
        '{OP_CSRFCZ, 4'h0, 5'h05, Z0, Z0, Z0, 0, Z0, 32'h0000_0023},
        '{OP_CSRF, 4'h0, 5'h01, Z0, Z0, Z0, 0, Z0, 32'h0000_0021},
        '{OP_MOVC_REG, 4'h2, 5'h00, Z0, 32'h0000_0777, Z0, 1, 32'h0000_0777, 32'h0000_0021}
    };
    alu_move_rotate_flag_ops u_alu_move_rotate_flag_ops (.ref_clk(ref_clk), .arst_n(arst_n),
        .core_rev(core_rev), .issue(issue), .wb(wb), .status_reg(status_reg), .busy(busy),
        .illegal(illegal));
    reg_file_model u_reg_file_model (.ref_clk(ref_clk), .arst_n(arst_n), .wb(wb),
        .rd_sel(rd_sel), .rd_data(rd_data));
    // ****************************************
    // clock, checks and the single exit
    // ****************************************
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task complete_run();
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // inputs move 1 ns after the edge, outputs are read there too
    task step();
        @(posedge ref_clk);
        #1;
    endtask : step
    task put(input alu_op_t op, input logic [4:0] idx, input logic lc);
        issue = '0;
        issue.valid = 1'b1;
        issue.op = op;
        issue.flag_bit_index = idx;
        issue.long_case = lc;
    endtask : put
    initial begin
        #(40 * 400);
        failures++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        check("reset status", Z0, status_reg);
        check("reset outputs", Z0, {wb.wr_en, busy, illegal});
        arst_n = 1'b1;
        step();
        // back to back, one op per cycle, rd follows the row number
        for (int i = 0; i < 15; i++) begin
            put(rows[i].op, rows[i].idx, 1'b0);
            {issue.condition_code_field, issue.dest_val} = {rows[i].cc, rows[i].dv};
            {issue.source_reg, issue.imm, issue.rd} = {rows[i].src, rows[i].imm, i[3:0]};
            step();
            check("wr_en", {31'h0, rows[i].ewr}, {31'h0, wb.wr_en});
            if (rows[i].ewr) begin
                check("data", rows[i].ed, wb.data);
                check("rd", {28'h0, i[3:0]}, {28'h0, wb.rd});
            end
            check("status", rows[i].esr, status_reg);
        end
        issue.valid = 1'b0;
        rd_sel = 4'h2;
        #1;
        check("skipped move kept", Z0, rd_data);
        core_rev = 4'h1;
        put(OP_MOVH, 5'h00, 1'b0);
        step();
        check("old rev movh", 32'h0000_0002, {30'h0, illegal, wb.wr_en});
        put(OP_SSRF, 5'h06, 1'b1);
        step();
        check("long set", 32'h0000_0061, status_reg);
        put(OP_MOV_IMM, 5'h00, 1'b0);
        issue.imm = 32'h0bad_0bad;
        check("busy 1", 32'h0000_0001, {30'h0, illegal, busy});
        step();
        issue.valid = 1'b0;
        check("busy 2", 32'h0000_0001, {30'h0, wb.wr_en, busy});
        step();
        check("busy end", Z0, {30'h0, wb.wr_en, busy});
        // set n so the signed conditions see n and v differ
        put(OP_SSRF, 5'h02, 1'b0);
        step();
        check("set n", 32'h0000_0065, status_reg);
        put(OP_MOVC_IMM, 5'h00, 1'b0);
        issue.condition_code_field = 4'ha;
        issue.imm = 32'h0000_1234;
        step();
        check("gt skipped", Z0, {31'h0, wb.wr_en});
        issue.condition_code_field = 4'hb;
        step();
        check("le taken", 32'h0000_1234, wb.wr_en ? wb.data : Z0);
        issue.condition_code_field = 4'h4;
        issue.op = OP_SRC;
        step();
        check("mi set", 32'h0000_0001, wb.data);
        issue.condition_code_field = 4'hc;
        step();
        check("hi clear", Z0, wb.data);
        issue.valid = 1'b0;
        step();
        arst_n = 1'b0;
        #5;
        check("mid reset", Z0, status_reg);
        complete_run();
    end
endmodule : alu_move_rotate_flag_ops_tb
